// ### core/hfpa_top.sv
module hfpa_top (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// host bus, one 16-bit half per access
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [hfpa_pkg::ADDR_W-1:0] host_addr,
	input wire logic [hfpa_pkg::HALF_W-1:0] host_wdata,
	output logic [hfpa_pkg::HALF_W-1:0] host_rdata,
	output logic host_rvalid,
	// receive status entries from the mac
	input wire logic rxs_valid,
	output logic rxs_ready,
	input wire logic [hfpa_pkg::WORD_W-1:0] rxs_data,
	// receive data words from the mac
	input wire logic rxd_valid,
	output logic rxd_ready,
	input wire logic [hfpa_pkg::WORD_W-1:0] rxd_data,
	// transmit status entries from the mac
	input wire logic txs_valid,
	output logic txs_ready,
	input wire logic [hfpa_pkg::WORD_W-1:0] txs_data,
	// transmit data words to the mac
	output logic txd_valid,
	input wire logic txd_ready,
	output logic [hfpa_pkg::WORD_W-1:0] txd_data
);
	import hfpa_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	hfpa_port_t port; // decoded target of the current access
	logic [ADDR_W-1:0] word_addr; // address with half select dropped
	logic half_hi; // access touches bits 31:16
	logic sw_rst; // one-cycle software reset
	logic all_rst_n; // low on any reset source
	logic [HALF_W-1:0] limit; // fifo capacities
	logic [EV_W-1:0] events; // event flags as read
	logic ev_rxd_under; // read of empty receive data
	logic ev_txd_over; // push into full transmit data
	logic ev_rxs_under; // pop of empty receive status
	logic ev_tx_space; // low once transmit data was full
	logic ev_rxs_seen; // high once receive status held data
	logic ev_swrst; // a software reset happened
	logic ev_read; // host reads the event register
	logic ev_clear; // host writes the event register
	logic rxd_pair; // low half of receive data already read
	logic txd_pair; // low half of transmit data already written
	logic rxs_pair; // low half of receive status pop read
	logic txs_pair; // low half of transmit status pop read
	logic [HALF_W-1:0] txd_low; // held low half of transmit word
	logic [WORD_W-1:0] rd_word; // full word behind the read address
	logic [HALF_W-1:0] next_rdata; // half of it that is returned
	logic rxs_pop; // remove receive status head
	logic rxd_pop; // remove receive data head
	logic txs_pop; // remove transmit status head
	logic txd_push; // complete transmit data word
	logic txd_in_ready; // transmit data has room
	logic rxs_out_valid; // receive status not empty
	logic rxd_out_valid; // receive data not empty
	logic txs_out_valid; // transmit status not empty
	logic [WORD_W-1:0] rxs_head; // oldest receive status
	logic [WORD_W-1:0] rxd_head; // oldest receive data
	logic [WORD_W-1:0] txs_head; // oldest transmit status
	logic [CNT_W-1:0] rxs_lvl; // fill levels
	logic [CNT_W-1:0] rxd_lvl;
	logic [CNT_W-1:0] txs_lvl;
	logic [CNT_W-1:0] txd_lvl;

	// ----------------------------------------------------------------
	// reset
	// ----------------------------------------------------------------

	// hardware and software reset both restore defaults
	assign all_rst_n = reset_n && !sw_rst;

	// software reset pulse from a write-only control bit
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sw_rst <= 1'b0;
		end else begin
			sw_rst <= host_wr && port == HFPA_PORT_CTRL && !half_hi && host_wdata[CTRL_SWRST_BIT];
		end
	end

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	assign word_addr = {host_addr[ADDR_W-1:2], 2'b00};
	assign half_hi = host_addr[1];

	// map the address onto one target, unknown words hit nothing
	always_comb begin
		port = HFPA_PORT_NONE;
		// sixteen half-word locations alias each data port
		if (host_addr[ADDR_W-1:DATA_SEL_LSB] == RXD_SEL) begin
			port = HFPA_PORT_RXD;
		end else if (host_addr[ADDR_W-1:DATA_SEL_LSB] == TXD_SEL) begin
			port = HFPA_PORT_TXD;
		end else begin
			// separate locations for each fifo and register
			case (word_addr)
				RXS_POP_OFS: port = HFPA_PORT_RXS_POP;
				RXS_PEEK_OFS: port = HFPA_PORT_RXS_PEEK;
				TXS_POP_OFS: port = HFPA_PORT_TXS_POP;
				TXS_PEEK_OFS: port = HFPA_PORT_TXS_PEEK;
				LIMIT_OFS: port = HFPA_PORT_LIMIT;
				CTRL_OFS: port = HFPA_PORT_CTRL;
				EVENT_OFS: port = HFPA_PORT_EVENT;
				LEVEL_OFS: port = HFPA_PORT_LEVEL;
				default: port = HFPA_PORT_NONE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// half pairing
	// ----------------------------------------------------------------

	// low half arms the pair, high half completes and disarms it
	always_ff @(posedge clk) begin
		if (!all_rst_n) begin
			rxd_pair <= 1'b0;
			txd_pair <= 1'b0;
			rxs_pair <= 1'b0;
			txs_pair <= 1'b0;
		end else begin
			if (host_rd && port == HFPA_PORT_RXD) begin
				rxd_pair <= !half_hi;
			end
			if (host_wr && port == HFPA_PORT_TXD) begin
				txd_pair <= !half_hi;
			end
			if (host_rd && port == HFPA_PORT_RXS_POP) begin
				rxs_pair <= !half_hi;
			end
			if (host_rd && port == HFPA_PORT_TXS_POP) begin
				txs_pair <= !half_hi;
			end
		end
	end

	// transmit low half waits here for its partner
	always_ff @(posedge clk) begin
		if (!all_rst_n) begin
			txd_low <= '0;
		end else if (host_wr && port == HFPA_PORT_TXD && !half_hi) begin
			txd_low <= host_wdata;
		end
	end

	// pops and push happen once, on the high half of an armed pair
	assign rxd_pop = host_rd && port == HFPA_PORT_RXD && half_hi && rxd_pair;
	assign rxs_pop = host_rd && port == HFPA_PORT_RXS_POP && half_hi && rxs_pair;
	assign txs_pop = host_rd && port == HFPA_PORT_TXS_POP && half_hi && txs_pair;
	assign txd_push = host_wr && port == HFPA_PORT_TXD && half_hi && txd_pair;

	// ----------------------------------------------------------------
	// fifos
	// ----------------------------------------------------------------

	// receive status, filled by the mac, drained only by host pops
	hfpa_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH), .CNT_W(CNT_W)) u_rxs (
		.clk(clk),
		.reset_n(all_rst_n),
		.limit(limit[LIM_RXS_LSB +: CNT_W]),
		.in_valid(rxs_valid),
		.in_ready(rxs_ready),
		.in_data(rxs_data),
		.out_valid(rxs_out_valid),
		.out_ready(rxs_pop),
		.out_data(rxs_head),
		.level(rxs_lvl)
	);

	// receive data, filled by the mac, drained only by host reads
	hfpa_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH), .CNT_W(CNT_W)) u_rxd (
		.clk(clk),
		.reset_n(all_rst_n),
		.limit(limit[LIM_RXD_LSB +: CNT_W]),
		.in_valid(rxd_valid),
		.in_ready(rxd_ready),
		.in_data(rxd_data),
		.out_valid(rxd_out_valid),
		.out_ready(rxd_pop),
		.out_data(rxd_head),
		.level(rxd_lvl)
	);

	// transmit status, filled by the mac, drained by host pops
	hfpa_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH), .CNT_W(CNT_W)) u_txs (
		.clk(clk),
		.reset_n(all_rst_n),
		.limit(limit[LIM_TXS_LSB +: CNT_W]),
		.in_valid(txs_valid),
		.in_ready(txs_ready),
		.in_data(txs_data),
		.out_valid(txs_out_valid),
		.out_ready(txs_pop),
		.out_data(txs_head),
		.level(txs_lvl)
	);

	// transmit data, filled by host word pairs, drained by the mac
	hfpa_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH), .CNT_W(CNT_W)) u_txd (
		.clk(clk),
		.reset_n(all_rst_n),
		.limit(limit[LIM_TXD_LSB +: CNT_W]),
		.in_valid(txd_push),
		.in_ready(txd_in_ready),
		.in_data({host_wdata, txd_low}),
		.out_valid(txd_valid),
		.out_ready(txd_ready),
		.out_data(txd_data),
		.level(txd_lvl)
	);

	// ----------------------------------------------------------------
	// capacity register
	// ----------------------------------------------------------------

	// only the low half holds fields; the high half is reserved
	always_ff @(posedge clk) begin
		if (!all_rst_n) begin
			limit <= LIMIT_RST;
		end else if (host_wr && port == HFPA_PORT_LIMIT && !half_hi) begin
			limit <= host_wdata;
		end
	end

	// ----------------------------------------------------------------
	// event flags
	// ----------------------------------------------------------------
	assign ev_read = host_rd && port == HFPA_PORT_EVENT && !half_hi;
	assign ev_clear = host_wr && port == HFPA_PORT_EVENT && !half_hi;

	// underrun and overrun, a new event wins over the clearing write
	always_ff @(posedge clk) begin
		if (!all_rst_n) begin
			ev_rxd_under <= 1'b0;
			ev_txd_over <= 1'b0;
		end else begin
			if (host_rd && port == HFPA_PORT_RXD && !rxd_out_valid) begin
				ev_rxd_under <= 1'b1;
			end else if (ev_clear && host_wdata[EV_RXD_UNDER]) begin
				ev_rxd_under <= 1'b0;
			end
			if (txd_push && !txd_in_ready) begin
				ev_txd_over <= 1'b1;
			end else if (ev_clear && host_wdata[EV_TXD_OVER]) begin
				ev_txd_over <= 1'b0;
			end
		end
	end

	// receive status pop of an empty fifo, cleared by reading the flags
	always_ff @(posedge clk) begin
		if (!all_rst_n) begin
			ev_rxs_under <= 1'b0;
		end else if (host_rd && port == HFPA_PORT_RXS_POP && !rxs_out_valid) begin
			ev_rxs_under <= 1'b1;
		end else if (ev_read) begin
			ev_rxs_under <= 1'b0;
		end
	end

	// latched levels: hold the captured state until the flags are read
	always_ff @(posedge clk) begin
		if (!all_rst_n) begin
			ev_tx_space <= EV_TX_SPACE_RST;
			ev_rxs_seen <= 1'b0;
		end else begin
			if (!txd_in_ready) begin
				ev_tx_space <= 1'b0;
			end else if (ev_read) begin
				ev_tx_space <= 1'b1;
			end
			if (rxs_out_valid) begin
				ev_rxs_seen <= 1'b1;
			end else if (ev_read) begin
				ev_rxs_seen <= 1'b0;
			end
		end
	end

	// software reset marker, cleared only by hardware reset or a write
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ev_swrst <= 1'b0;
		end else if (sw_rst) begin
			ev_swrst <= 1'b1;
		end else if (ev_clear && host_wdata[EV_SWRST]) begin
			ev_swrst <= 1'b0;
		end
	end

	// gather flags into their read positions
	always_comb begin
		events = '0;
		events[EV_RXD_UNDER] = ev_rxd_under;
		events[EV_TXD_OVER] = ev_txd_over;
		events[EV_RXS_UNDER] = ev_rxs_under;
		events[EV_TX_SPACE] = ev_tx_space;
		events[EV_RXS_SEEN] = ev_rxs_seen;
		events[EV_SWRST] = ev_swrst;
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------

	// word behind the address; write-only and unmapped words read zero
	always_comb begin
		rd_word = '0;
		unique case (port)
			HFPA_PORT_RXD: rd_word = rxd_out_valid ? rxd_head : '0;
			HFPA_PORT_RXS_POP: rd_word = rxs_out_valid ? rxs_head : '0;
			HFPA_PORT_RXS_PEEK: rd_word = rxs_out_valid ? rxs_head : '0;
			HFPA_PORT_TXS_POP: rd_word = txs_out_valid ? txs_head : '0;
			HFPA_PORT_TXS_PEEK: rd_word = txs_out_valid ? txs_head : '0;
			HFPA_PORT_LIMIT: rd_word = {{(WORD_W - HALF_W){1'b0}}, limit};
			HFPA_PORT_EVENT: rd_word = {{(WORD_W - EV_W){1'b0}}, events};
			HFPA_PORT_LEVEL: rd_word = {{(WORD_W - 4 * CNT_W){1'b0}}, txd_lvl, txs_lvl, rxd_lvl, rxs_lvl};
			HFPA_PORT_TXD: rd_word = '0;
			HFPA_PORT_CTRL: rd_word = '0;
			HFPA_PORT_NONE: rd_word = '0;
		endcase
		next_rdata = half_hi ? rd_word[WORD_W-1:HALF_W] : rd_word[HALF_W-1:0];
	end

	// read answer one cycle after the strobe
	always_ff @(posedge clk) begin
		if (!all_rst_n) begin
			host_rdata <= '0;
			host_rvalid <= 1'b0;
		end else begin
			host_rvalid <= host_rd;
			host_rdata <= host_rd ? next_rdata : '0;
		end
	end

endmodule : hfpa_top

// ### core/hfpa_pkg.sv
// ----------------------------------------------------------------
// shared constants for the host fifo port block
// ----------------------------------------------------------------
package hfpa_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8; // host byte address of one 16-bit half
	localparam int HALF_W = 16; // host bus width
	localparam int WORD_W = 32; // internal datapath width
	localparam int FIFO_DEPTH = 8; // entries per fifo
	localparam int CNT_W = 4; // fill level width, holds 0..8

	// ----------------------------------------------------------------
	// address map, byte offsets of 32-bit words
	// ----------------------------------------------------------------
	localparam logic [2:0] RXD_SEL = 3'h0; // 00h-1eh, sixteen half-word aliases
	localparam logic [2:0] TXD_SEL = 3'h1; // 20h-3eh, sixteen half-word aliases
	localparam int DATA_SEL_LSB = 5; // address bits from this one up pick a data port
	localparam logic [ADDR_W-1:0] RXS_POP_OFS = 8'h40;
	localparam logic [ADDR_W-1:0] RXS_PEEK_OFS = 8'h44;
	localparam logic [ADDR_W-1:0] TXS_POP_OFS = 8'h48;
	localparam logic [ADDR_W-1:0] TXS_PEEK_OFS = 8'h4c;
	localparam logic [ADDR_W-1:0] LIMIT_OFS = 8'h50; // read/write fifo capacities
	localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h54; // write-only control
	localparam logic [ADDR_W-1:0] EVENT_OFS = 8'h58; // event flags
	localparam logic [ADDR_W-1:0] LEVEL_OFS = 8'h5c; // read-only fill levels

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int LIM_RXS_LSB = 0;
	localparam int LIM_RXD_LSB = 4;
	localparam int LIM_TXS_LSB = 8;
	localparam int LIM_TXD_LSB = 12;
	localparam logic [HALF_W-1:0] LIMIT_RST = 16'h8888;
	localparam int CTRL_SWRST_BIT = 0;
	localparam int EV_RXD_UNDER = 0; // write_one_to_clear
	localparam int EV_TXD_OVER = 1; // write_one_to_clear
	localparam int EV_RXS_UNDER = 2; // clear_on_read
	localparam int EV_TX_SPACE = 3; // latched_low_bit
	localparam int EV_RXS_SEEN = 4; // latched_high_bit
	localparam int EV_SWRST = 5; // write_one_to_clear, software_reset_immune
	localparam int EV_W = 6;
	localparam logic EV_TX_SPACE_RST = 1'b1;

	// ----------------------------------------------------------------
	// decoded host target
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		HFPA_PORT_NONE = 4'h0,
		HFPA_PORT_RXD = 4'h1,
		HFPA_PORT_TXD = 4'h2,
		HFPA_PORT_RXS_POP = 4'h3,
		HFPA_PORT_RXS_PEEK = 4'h4,
		HFPA_PORT_TXS_POP = 4'h5,
		HFPA_PORT_TXS_PEEK = 4'h6,
		HFPA_PORT_LIMIT = 4'h7,
		HFPA_PORT_CTRL = 4'h8,
		HFPA_PORT_EVENT = 4'h9,
		HFPA_PORT_LEVEL = 4'ha
	} hfpa_port_t;

endpackage : hfpa_pkg

// ### core/hfpa_fifo.sv
// ----------------------------------------------------------------
// fifo with a run-time capacity limit
// ----------------------------------------------------------------
module hfpa_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8,
	parameter int CNT_W = 4
) (
	// clock and synchronous reset
	input wire logic clk,
	input wire logic reset_n,
	// capacity, zero means full depth
	input wire logic [CNT_W-1:0] limit,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// current fill level
	output logic [CNT_W-1:0] level
);

	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [CNT_W-1:0] DEPTH_CNT = CNT_W'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // storage
	logic [PTR_W-1:0] wr_ptr; // next slot to fill
	logic [PTR_W-1:0] rd_ptr; // oldest entry
	logic [CNT_W-1:0] count; // entries held
	logic [CNT_W-1:0] eff_limit; // limit clipped to depth
	logic do_push; // entry accepted
	logic do_pop; // entry removed

	// limit of zero or above depth falls back to the full depth
	assign eff_limit = (limit == '0 || limit > DEPTH_CNT) ? DEPTH_CNT : limit;
	assign in_ready = count < eff_limit;
	assign out_valid = count != '0;
	assign out_data = mem[rd_ptr];
	assign level = count;
	assign do_push = in_valid && in_ready;
	assign do_pop = out_valid && out_ready;

	// storage write, no reset needed on data
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// pointers and count
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (do_pop) begin
				rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (do_push && !do_pop) begin
				count <= count + 1'b1;
			end else if (do_pop && !do_push) begin
				count <= count - 1'b1;
			end
		end
	end

endmodule : hfpa_fifo

// ### verif/hfpa_properties.sv
// ----------------------------------------------------------------
// port checker for the host fifo block
// ----------------------------------------------------------------
module hfpa_properties (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// host bus
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [hfpa_pkg::ADDR_W-1:0] host_addr,
	input wire logic [hfpa_pkg::HALF_W-1:0] host_rdata,
	input wire logic host_rvalid,
	// mac side
	input wire logic rxs_ready,
	input wire logic rxd_valid,
	input wire logic rxd_ready,
	input wire logic txs_ready,
	input wire logic txd_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	import hfpa_pkg::*;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	wire logic at_txd = host_addr[7:5] == TXD_SEL; // transmit data aliases
	wire logic at_rxd = host_addr[7:5] == RXD_SEL; // receive data aliases
	// low then high half of one word, back to back
	sequence s_txd_pair;
		host_wr && at_txd && !host_addr[1] ##1 host_wr && at_txd && host_addr[1];
	endsequence
	sequence s_rxd_pair;
		host_rd && at_rxd && !host_addr[1] ##1 host_rd && at_rxd && host_addr[1];
	endsequence
	a_read_answer_timing: assert property (host_rd |=> host_rvalid)
		else $error("read got no answer");
	a_answer_has_cause: assert property (host_rvalid |-> $past(host_rd))
		else $error("answer without read");
	a_ctrl_reads_zero: assert property (host_rd && host_addr[7:2] == CTRL_OFS[7:2] |=> host_rdata == '0)
		else $error("control read not zero");
	a_txd_reads_zero: assert property (host_rd && at_txd |=> host_rdata == '0)
		else $error("transmit port read not zero");
	a_txd_pair_push: assert property (s_txd_pair |=> txd_valid)
		else $error("word pair not pushed");
	a_rxd_pop_frees: assert property ((s_rxd_pair ##0 !rxd_ready) |=> rxd_ready)
		else $error("pop left no room");
	a_reset_empty: assert property ($rose(reset_n) |-> !txd_valid && rxs_ready && rxd_ready && txs_ready)
		else $error("fifos not empty after reset");
	a_ready_fall_cause: assert property ($fell(rxd_ready) |-> $past(rxd_valid) || $past(host_wr))
		else $error("receive fill changed by a read");
endmodule : hfpa_properties

bind hfpa_top hfpa_properties i_hfpa_properties (
	.clk(clk), .reset_n(reset_n), .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr),
	.host_rdata(host_rdata), .host_rvalid(host_rvalid), .rxs_ready(rxs_ready), .rxd_valid(rxd_valid),
	.rxd_ready(rxd_ready), .txs_ready(txs_ready), .txd_valid(txd_valid)
);

// ### verif/hfpa_host_model.sv
// ----------------------------------------------------------------
// host processor model, one 16-bit half per access
// ----------------------------------------------------------------
module hfpa_host_model (
	// clock
	input wire logic clk,
	// requests
	output logic host_rd,
	output logic host_wr,
	output logic [hfpa_pkg::ADDR_W-1:0] host_addr,
	output logic [hfpa_pkg::HALF_W-1:0] host_wdata,
	// answers
	input wire logic [hfpa_pkg::HALF_W-1:0] host_rdata,
	input wire logic host_rvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	import hfpa_pkg::*;
	// idle bus at time zero
	initial begin
		host_rd <= 1'b0;
		host_wr <= 1'b0;
		host_addr <= 8'h00;
		host_wdata <= 16'h0000;
	end
	// answer data, unknown when no answer came
	function automatic logic [HALF_W-1:0] answer();
		return host_rvalid === 1'b1 ? host_rdata : 'x;
	endfunction : answer
	// prompt or slow start of a request
	task automatic start();
		repeat ($urandom_range(0, 2)) @(posedge clk);
		@(posedge clk);
	endtask : start
	// strobes low, stale address and data inverted
	task automatic drop_bus();
		@(posedge clk);
		host_rd <= 1'b0;
		host_wr <= 1'b0;
		host_addr <= ~host_addr;
		host_wdata <= ~host_wdata;
	endtask : drop_bus
	task automatic rd_half(input logic [ADDR_W-1:0] a, output logic [HALF_W-1:0] d);
		start();
		host_rd <= 1'b1;
		host_addr <= a;
		drop_bus();
		#1;
		d = answer();
	endtask : rd_half
	// a word is its low half then its high half
	task automatic rd_word(input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] d);
		start();
		host_rd <= 1'b1;
		host_addr <= a & 8'hfd;
		@(posedge clk);
		host_addr <= a | 8'h02;
		#1;
		d[15:0] = answer();
		drop_bus();
		#1;
		d[31:16] = answer();
	endtask : rd_word
	task automatic wr_half(input logic [ADDR_W-1:0] a, input logic [HALF_W-1:0] d);
		start();
		host_wr <= a < 8'h60; // no writes to reserved words
		host_addr <= a;
		host_wdata <= a[7:2] == CTRL_OFS[7:2] ? d & 16'h0001 : d; // reserved bits zero
		drop_bus();
	endtask : wr_half
	task automatic wr_word(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
		start();
		host_wr <= 1'b1;
		host_addr <= a & 8'hfd;
		host_wdata <= d[15:0];
		@(posedge clk);
		host_addr <= a | 8'h02;
		host_wdata <= d[31:16];
		drop_bus();
	endtask : wr_word
endmodule : hfpa_host_model

// ### verif/hfpa_top_tb.sv
// ----------------------------------------------------------------
// self-checking bench for the host fifo block
// ----------------------------------------------------------------
module hfpa_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import hfpa_pkg::*;
	logic clk = 1'b0; // 25 MHz
	logic reset_n = 1'b0; // synchronous, active low
	logic host_rd;
	logic host_wr;
	logic [ADDR_W-1:0] host_addr;
	logic [HALF_W-1:0] host_wdata;
	logic [HALF_W-1:0] host_rdata;
	logic host_rvalid;
	logic [2:0] mac_valid = 3'h0; // rxs, rxd, txs pushes
	logic [WORD_W-1:0] mac_data = 32'h0; // shared push data
	wire logic [2:0] mac_ready;
	logic txd_valid;
	logic txd_ready = 1'b0; // random stall when draining
	logic drain_en = 1'b0;
	logic [WORD_W-1:0] txd_data;
	logic [WORD_W-1:0] txq[$]; // words due at the transmit side
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;
	hfpa_top i_hfpa_top (
		.clk(clk), .reset_n(reset_n), .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
		.rxs_valid(mac_valid[0]), .rxs_ready(mac_ready[0]), .rxs_data(mac_data),
		.rxd_valid(mac_valid[1]), .rxd_ready(mac_ready[1]), .rxd_data(mac_data),
		.txs_valid(mac_valid[2]), .txs_ready(mac_ready[2]), .txs_data(mac_data),
		.txd_valid(txd_valid), .txd_ready(txd_ready), .txd_data(txd_data)
	);
	hfpa_host_model u_host (
		.clk(clk), .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid)
	);
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic print_verdict();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict
	task automatic check(input string what, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check
	// read one half and compare its masked bits
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [HALF_W-1:0] m, input logic [HALF_W-1:0] e,
		input string what);
		logic [HALF_W-1:0] h;
		u_host.rd_half(a, h);
		check(what, 32'(h & m), 32'(e));
	endtask : rd_chk
	// mac push, held until ready is seen at an edge
	task automatic push(input int sel, input logic [WORD_W-1:0] d);
		@(posedge clk);
		mac_valid[sel] <= 1'b1;
		mac_data <= d;
		do @(posedge clk); while (mac_ready[sel] !== 1'b1);
		mac_valid[sel] <= 1'b0;
		mac_data <= ~d;
	endtask : push
	// transmit side: random stalls, every word taken compared in order
	always @(posedge clk) begin
		if (txd_valid === 1'b1 && txd_ready === 1'b1) begin
			check("txd word", txd_data, txq.size() > 0 ? txq.pop_front() : 'x);
		end
		txd_ready <= drain_en & 1'($urandom);
	end
	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	initial begin
		logic [WORD_W-1:0] d;
		logic [WORD_W-1:0] q[$];
		logic [ADDR_W-1:0] ofs;
		void'($urandom(11));
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rd_chk(LIMIT_OFS, 16'hffff, LIMIT_RST, "limit");
		rd_chk(EVENT_OFS, 16'hffff, 16'h0008, "event");
		rd_chk(CTRL_OFS, 16'hffff, 16'h0000, "ctrl");
		rd_chk(8'h24, 16'hffff, 16'h0000, "txd port");
		// status fifos: peek keeps, lone high half keeps, pairs pop
		for (int k = 0; k < 2; k++) begin
			ofs = k ? TXS_POP_OFS : RXS_POP_OFS;
			for (int i = 0; i < 3; i++) begin
				d = $urandom;
				q.push_back(d);
				push(2 * k, d);
			end
			rd_chk(LEVEL_OFS, k ? 16'h0f00 : 16'h000f, k ? 16'h0300 : 16'h0003, "level");
			repeat (2) begin
				u_host.rd_word(ofs + 8'h04, d);
				check("peek", d, q[0]);
			end
			rd_chk(ofs + 8'h02, 16'hffff, q[0][31:16], "lone high");
			while (q.size() > 0) begin
				u_host.rd_word(ofs, d);
				check("pop", d, q.pop_front());
			end
			u_host.rd_word(ofs, d);
			check("empty pop", d, 32'h0);
		end
		rd_chk(EVENT_OFS, 16'h001c, 16'h001c, "event set");
		rd_chk(EVENT_OFS, 16'h001c, 16'h0008, "event read");
		// receive data: capacity two, refused writes, random aliases
		u_host.wr_half(LIMIT_OFS, 16'h8828);
		for (int i = 0; i < 2; i++) begin
			d = $urandom;
			q.push_back(d);
			push(1, d);
		end
		#1;
		check("rxd ready", 32'(mac_ready[1]), 32'h0);
		u_host.wr_half(LEVEL_OFS, 16'hffff);
		u_host.wr_word(8'h04, 32'h12345678);
		rd_chk(LEVEL_OFS, 16'hffff, 16'h0020, "rxd level");
		while (q.size() > 0) begin
			u_host.rd_word(8'($urandom_range(0, 7) * 4), d);
			check("rxd pop", d, q.pop_front());
		end
		rd_chk(8'h1c, 16'hffff, 16'h0000, "rxd empty");
		rd_chk(EVENT_OFS, 16'h0001, 16'h0001, "underrun");
		u_host.wr_half(EVENT_OFS, 16'h0000);
		rd_chk(EVENT_OFS, 16'h0001, 16'h0001, "write zero");
		u_host.wr_half(EVENT_OFS, 16'h0001);
		rd_chk(EVENT_OFS, 16'h0001, 16'h0000, "write one");
		u_host.wr_half(LIMIT_OFS, LIMIT_RST);
		// transmit data: lone high half, fill past full, drain with stalls
		u_host.wr_half(8'h26, 16'hdead);
		@(posedge clk);
		#1;
		check("lone push", 32'(txd_valid), 32'h0);
		for (int i = 0; i <= FIFO_DEPTH; i++) begin
			d = $urandom;
			if (i < FIFO_DEPTH) txq.push_back(d);
			u_host.wr_word(8'(8'h20 + $urandom_range(0, 7) * 4), d);
		end
		rd_chk(EVENT_OFS, 16'h000a, 16'h0002, "full");
		drain_en <= 1'b1;
		for (int i = 0; i < 400 && txq.size() > 0; i++) @(posedge clk);
		check("drained", 32'(txq.size()), 32'h0);
		rd_chk(EVENT_OFS, 16'h000a, 16'h0002, "space held");
		rd_chk(EVENT_OFS, 16'h000a, 16'h000a, "space back");
		u_host.wr_half(EVENT_OFS, 16'h0002);
		rd_chk(EVENT_OFS, 16'h0002, 16'h0000, "overrun");
		// software reset keeps only its own flag
		u_host.wr_half(LIMIT_OFS, 16'h1111);
		rd_chk(8'h00, 16'hffff, 16'h0000, "rxd empty");
		push(0, 32'h0);
		u_host.wr_half(CTRL_OFS, 16'h0001);
		repeat (2) @(posedge clk);
		rd_chk(LIMIT_OFS, 16'hffff, LIMIT_RST, "limit swrst");
		rd_chk(LEVEL_OFS, 16'hffff, 16'h0000, "level swrst");
		rd_chk(EVENT_OFS, 16'hffff, 16'h0028, "event swrst");
		u_host.wr_half(EVENT_OFS, 16'h0020);
		rd_chk(EVENT_OFS, 16'hffff, 16'h0008, "swrst flag");
		print_verdict();
	end
endmodule : hfpa_top_tb
